// File: verilog/fld_config.sv
// Flash LED driver configuration bank with ramp, safety and inhibit sequencing
// ==========================================================
// Overview of operation
// [RULE_01] Strobe code maps to 100..533 mA by thirds, 600, 700, then 100 mA steps to 1600.
// [RULE_02] Strobe current ramps 100 mA per 16, 32, 64 or 128 us interval.
// [RULE_03] Derated level is 100 mA plus 100 mA per code step.
// [RULE_04] Steady-light level runs 33 mA to 533 mA in thirds of 100 mA.
// [RULE_05] Steady-light current ramps 33 mA per 64, 128, 256 or 512 us interval.
// [RULE_06] Lower brownout threshold is 2.75, 2.9, 3.05 or 3.2 V.
// [RULE_07] Upper brownout threshold is 2.9, 3.05, 3.2 or 3.35 V.
// [RULE_08] Boost peak limit is 1.8, 2.4, 3.0 or 3.6 A.
// [RULE_09] A strobe pulse lasts at most 32 ms doubled per code step.
// [RULE_10] After a pulse the strobe stays off 512 ms times code plus one.
// [RULE_11] Duration limit and off time each act only while their enable is set.
// [RULE_12] A pulse ended by the duration limit sets a read-clear timeout flag.
// [RULE_13] Duration codes 6 and 7 act as the longest defined duration.
// [RULE_14] Only defined bits are stored; new settings apply at the next ramp step. Thresholds and timer fields apply without waiting for a ramp step.
`include "fld_params.svh"

module fld_config import fld_pkg::*; #(
  parameter int CYC_PER_US = `FLD_TICK_CYCLES,  // Clock cycles per microsecond
  parameter int US_PER_MS  = `FLD_MS_IN_US      // Microseconds per millisecond
) (
  input  wire logic        clock_i,                // System clock, 50 MHz
  input  wire logic        rst_n_i,                // Async reset, active low
  input  wire logic [7:0]  reg_addr_i,             // Register offset
  input  wire logic [7:0]  reg_wdata_i,            // Write data
  input  wire logic        reg_wr_i,               // Write strobe
  input  wire logic        reg_rd_i,               // Read strobe
  output logic      [7:0]  reg_rdata_o,            // Read data, next cycle
  input  wire logic        strobe_req_i,           // Strobe request level
  input  wire logic        reduced_i,              // Use derated level in strobe
  input  wire logic        steady_req_i,           // Steady light request
  input  wire logic        safety_en_i,            // Duration limit enable
  input  wire logic        inhibit_en_i,           // Post-pulse off time enable
  output fld_ma_t          led_current_ma_o,       // Ramped LED current, mA
  output logic             strobe_active_o,        // Strobe pulse running
  output logic             inhibit_active_o,       // Off time running
  output logic      [11:0] brownout_lower_mv_o,    // Lower lockout threshold, mV
  output logic      [11:0] brownout_upper_mv_o,    // Upper lockout threshold, mV
  output logic      [11:0] boost_peak_limit_ma_o   // Boost peak current, mA
);

  // ==========================================================
  // Registers
  logic [6:0] strobe_level_cfg;
  logic [3:0] reduced_level_cfg;
  logic [5:0] steady_light_cfg;
  logic [5:0] protection_cfg;
  logic [6:0] strobe_timer_cfg;
  logic       timeout_flag;
  logic       timeout_evt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_level_cfg  <= `FLD_RST_STROBE_LEVEL;
      reduced_level_cfg <= `FLD_RST_REDUCED_LEVEL;
      steady_light_cfg  <= `FLD_RST_STEADY_LIGHT;
      protection_cfg    <= `FLD_RST_PROTECTION;
      strobe_timer_cfg  <= `FLD_RST_STROBE_TIMER;
    end else if (reg_wr_i) begin
      // Spare bits are dropped on write
      unique case (reg_addr_i)
        `FLD_ADDR_STROBE_LEVEL:  strobe_level_cfg  <= reg_wdata_i[6:0]; // [RULE_14]
        `FLD_ADDR_REDUCED_LEVEL: reduced_level_cfg <= reg_wdata_i[3:0]; // [RULE_14]
        `FLD_ADDR_STEADY_LIGHT:  steady_light_cfg  <= reg_wdata_i[5:0]; // [RULE_14]
        `FLD_ADDR_PROTECTION:    protection_cfg    <= reg_wdata_i[5:0]; // [RULE_14]
        `FLD_ADDR_STROBE_TIMER:  strobe_timer_cfg  <= reg_wdata_i[6:0]; // [RULE_14]
        default: ;
      endcase
    end
  end

  // Event wins over a clearing read in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_flag <= 1'b0;
    end else if (timeout_evt) begin
      timeout_flag <= 1'b1; // [RULE_12]
    end else if (reg_rd_i && reg_addr_i == `FLD_ADDR_STROBE_STATUS) begin
      timeout_flag <= 1'b0; // [RULE_12]
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FLD_ADDR_STROBE_LEVEL:  reg_rdata_o <= {1'b0, strobe_level_cfg};
        `FLD_ADDR_REDUCED_LEVEL: reg_rdata_o <= {4'h0, reduced_level_cfg};
        `FLD_ADDR_STEADY_LIGHT:  reg_rdata_o <= {2'h0, steady_light_cfg};
        `FLD_ADDR_PROTECTION:    reg_rdata_o <= {2'h0, protection_cfg};
        `FLD_ADDR_STROBE_TIMER:  reg_rdata_o <= {1'b0, strobe_timer_cfg};
        `FLD_ADDR_STROBE_STATUS: reg_rdata_o <= {7'h00, timeout_flag};
        default:                 reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Level decode
  function automatic fld_ma_t fld_third(input logic [4:0] n);
    logic [11:0] p;
    p = 12'(n) * 12'h064;
    return 11'(p / 12'h003);
  endfunction

  logic [4:0] strobe_code;
  fld_ma_t    strobe_ma;
  fld_ma_t    derated_ma;
  fld_ma_t    steady_ma;

  assign strobe_code = strobe_level_cfg[`FLD_STROBE_CODE_MSB:`FLD_STROBE_CODE_LSB];

  always_comb begin
    if (strobe_code <= 5'h0d) begin
      strobe_ma = `FLD_STROBE_STEP_MA + fld_third(strobe_code); // [RULE_01]
    end else if (strobe_code == 5'h0e) begin
      strobe_ma = 11'h258; // [RULE_01]
    end else if (strobe_code == 5'h0f) begin
      strobe_ma = 11'h2bc; // [RULE_01]
    end else if (strobe_code >= 5'h18) begin
      strobe_ma = `FLD_STROBE_MAX_MA; // [RULE_01]
    end else begin
      strobe_ma = 11'h320 + 11'(strobe_code - 5'h10) * `FLD_STROBE_STEP_MA; // [RULE_01]
    end
  end

  assign derated_ma = `FLD_STROBE_STEP_MA * (11'(reduced_level_cfg) + 11'h001); // [RULE_03]
  assign steady_ma  = fld_third(5'(steady_light_cfg[3:0]) + 5'h01); // [RULE_04]

  // ==========================================================
  // Time base
  logic        us_tick;
  logic        ms_tick;
  logic        ramp_tick;
  logic        seq_change;
  logic        strobe_mode_q;
  logic        strobe_mode;
  logic [11:0] ramp_us;
  logic [13:0] ms_cnt;

  fld_tick #(.W(12)) u_us_tick (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .clr_i    (1'b0),
    .inc_i    (1'b1),
    .period_i (12'(CYC_PER_US)),
    .tick_o   (us_tick)
  );

  // Restarted on each sequencer change so timed phases start on a full millisecond
  fld_tick #(.W(12)) u_ms_tick (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .clr_i    (seq_change),
    .inc_i    (us_tick),
    .period_i (12'(US_PER_MS)),
    .tick_o   (ms_tick)
  );

  fld_tick #(.W(12)) u_ramp_tick (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .clr_i    (strobe_mode != strobe_mode_q),
    .inc_i    (us_tick),
    .period_i (ramp_us),
    .tick_o   (ramp_tick)
  );

  // ==========================================================
  // Strobe sequencer
  fld_seq_t    seq;
  fld_seq_t    next_seq;
  logic        req_q;
  logic [13:0] safety_ms;
  logic [13:0] inhibit_ms;
  logic        safety_done;
  logic [2:0]  safety_code;

  assign safety_code = strobe_timer_cfg[`FLD_SAFETY_MSB:`FLD_SAFETY_LSB];
  // Undefined codes never lengthen a pulse past the longest defined one
  assign safety_ms = `FLD_SAFETY_BASE_MS << ((safety_code > `FLD_SAFETY_MAX_CODE) ?
                     `FLD_SAFETY_MAX_CODE : safety_code); // [RULE_09] [RULE_13]
  assign inhibit_ms = `FLD_INHIBIT_STEP_MS *
                      (14'(strobe_timer_cfg[`FLD_INHIBIT_MSB:`FLD_INHIBIT_LSB]) + 14'h0001); // [RULE_10]
  assign safety_done = safety_en_i && ms_cnt >= safety_ms; // [RULE_09] [RULE_11]
  assign timeout_evt = seq == seq_strobe && strobe_req_i && safety_done; // [RULE_12]
  assign seq_change  = next_seq != seq;
  assign strobe_mode = seq == seq_strobe;

  always_comb begin
    next_seq = seq;
    unique case (seq)
      seq_idle: begin
        // A fresh rising request is needed, so a held request cannot retrigger
        if (strobe_req_i && !req_q) begin
          next_seq = seq_strobe;
        end
      end
      seq_strobe: begin
        if (!strobe_req_i || safety_done) begin
          next_seq = inhibit_en_i ? seq_inhibit : seq_idle; // [RULE_11]
        end
      end
      seq_inhibit: begin
        if (!inhibit_en_i || ms_cnt >= inhibit_ms) begin
          next_seq = seq_idle; // [RULE_10] [RULE_11]
        end
      end
      default: next_seq = seq_idle;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq              <= seq_idle;
      req_q            <= 1'b0;
      strobe_active_o  <= 1'b0;
      inhibit_active_o <= 1'b0;
      strobe_mode_q    <= 1'b0;
    end else begin
      seq              <= next_seq;
      req_q            <= strobe_req_i;
      strobe_active_o  <= next_seq == seq_strobe;
      inhibit_active_o <= next_seq == seq_inhibit;
      strobe_mode_q    <= strobe_mode;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt <= 14'h0000;
    end else if (seq_change) begin
      ms_cnt <= 14'h0000;
    end else if (ms_tick && ms_cnt != 14'h3fff) begin
      ms_cnt <= ms_cnt + 14'h0001;
    end
  end

  // ==========================================================
  // Current ramp
  fld_ma_t target_ma;
  fld_ma_t step_ma;
  logic [1:0] slew_sel;

  always_comb begin
    if (strobe_mode) begin
      target_ma = reduced_i ? derated_ma : strobe_ma;
      step_ma   = `FLD_STROBE_STEP_MA; // [RULE_02]
      slew_sel  = strobe_level_cfg[`FLD_STROBE_SLEW_MSB:`FLD_STROBE_SLEW_LSB];
      ramp_us   = `FLD_STROBE_SLEW_BASE_US << slew_sel; // [RULE_02]
    end else begin
      target_ma = steady_req_i ? steady_ma : 11'h000;
      step_ma   = `FLD_STEADY_STEP_MA; // [RULE_05]
      slew_sel  = steady_light_cfg[`FLD_STEADY_SLEW_MSB:`FLD_STEADY_SLEW_LSB];
      ramp_us   = `FLD_STEADY_SLEW_BASE_US << slew_sel; // [RULE_05]
    end
  end

  // Switching off is immediate; only rises and level changes are slewed
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_current_ma_o <= 11'h000;
    end else if (target_ma == 11'h000) begin
      led_current_ma_o <= 11'h000;
    end else if (ramp_tick) begin
      if (led_current_ma_o + step_ma <= target_ma) begin
        led_current_ma_o <= led_current_ma_o + step_ma; // [RULE_02] [RULE_05] [RULE_14]
      end else if (led_current_ma_o < target_ma) begin
        led_current_ma_o <= target_ma;
      end else if (led_current_ma_o >= target_ma + step_ma) begin
        led_current_ma_o <= led_current_ma_o - step_ma;
      end else begin
        led_current_ma_o <= target_ma;
      end
    end
  end

  // ==========================================================
  // Analog thresholds
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brownout_lower_mv_o   <= `FLD_BO_LOWER_BASE_MV;
      brownout_upper_mv_o   <= `FLD_BO_UPPER_BASE_MV;
      boost_peak_limit_ma_o <= `FLD_PEAK_BASE_MA;
    end else begin
      brownout_lower_mv_o <= `FLD_BO_LOWER_BASE_MV + `FLD_BO_STEP_MV *
        12'(protection_cfg[`FLD_BO_LOWER_MSB:`FLD_BO_LOWER_LSB]); // [RULE_06]
      brownout_upper_mv_o <= `FLD_BO_UPPER_BASE_MV + `FLD_BO_STEP_MV *
        12'(protection_cfg[`FLD_BO_UPPER_MSB:`FLD_BO_UPPER_LSB]); // [RULE_07]
      boost_peak_limit_ma_o <= `FLD_PEAK_BASE_MA + `FLD_PEAK_STEP_MA *
        12'(protection_cfg[`FLD_PEAK_LIMIT_MSB:`FLD_PEAK_LIMIT_LSB]); // [RULE_08]
    end
  end

  // ==========================================================
  // Assertions
  property p_strobe_map;
    @(posedge clock_i) disable iff (!rst_n_i)
      (strobe_code >= 5'h18 |-> strobe_ma == 11'h640) and
      (strobe_code == 5'h01 |-> strobe_ma == 11'h085) and
      (strobe_code == 5'h11 |-> strobe_ma == 11'h384);
  endproperty
  a_strobe_map: assert property (p_strobe_map) // [RULE_01]
    else $error("strobe level decode wrong");

  property p_strobe_step;
    @(posedge clock_i) disable iff (!rst_n_i)
      (strobe_mode && $past(strobe_mode) && led_current_ma_o > $past(led_current_ma_o))
      |-> (led_current_ma_o - $past(led_current_ma_o) <= 11'h064) && $past(ramp_tick);
  endproperty
  a_strobe_step: assert property (p_strobe_step) // [RULE_02]
    else $error("strobe ramp step too large or off tick");

  property p_derated;
    @(posedge clock_i) disable iff (!rst_n_i)
      reduced_level_cfg == 4'hf |-> derated_ma == 11'h640;
  endproperty
  a_derated: assert property (p_derated) // [RULE_03]
    else $error("derated top code not 1600 mA");

  property p_steady_map;
    @(posedge clock_i) disable iff (!rst_n_i)
      (steady_light_cfg[3:0] == 4'h0 |-> steady_ma == 11'h021) and
      (steady_light_cfg[3:0] == 4'h2 |-> steady_ma == 11'h064) and
      (steady_light_cfg[3:0] == 4'hf |-> steady_ma == 11'h215);
  endproperty
  a_steady_map: assert property (p_steady_map) // [RULE_04]
    else $error("steady level decode wrong");

  property p_steady_step;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!strobe_mode && $past(!strobe_mode) && led_current_ma_o > $past(led_current_ma_o))
      |-> led_current_ma_o - $past(led_current_ma_o) <= 11'h021;
  endproperty
  a_steady_step: assert property (p_steady_step) // [RULE_05]
    else $error("steady ramp step too large");

  property p_thresholds;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 protection_cfg == $past(protection_cfg) |->
        (brownout_lower_mv_o == 12'hc80 || protection_cfg[1:0] != 2'h3) &&
        (brownout_upper_mv_o == 12'hd16 || protection_cfg[3:2] != 2'h3) &&
        (boost_peak_limit_ma_o == 12'he10 || protection_cfg[5:4] != 2'h3);
  endproperty
  a_thresholds: assert property (p_thresholds) // [RULE_06] [RULE_07] [RULE_08]
    else $error("threshold outputs wrong for top codes");

  property p_timeout_cause;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(timeout_flag) |-> $past(seq) == seq_strobe && $past(safety_en_i)
        && $past(ms_cnt) >= $past(safety_ms);
  endproperty
  a_timeout_cause: assert property (p_timeout_cause) // [RULE_09] [RULE_12]
    else $error("timeout flag without expired limit");

  property p_inhibit_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      (seq == seq_inhibit && inhibit_en_i && ms_cnt < inhibit_ms) |=> seq == seq_inhibit;
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) // [RULE_10]
    else $error("off time ended early");

  property p_no_limit;
    @(posedge clock_i) disable iff (!rst_n_i)
      (seq == seq_strobe && !safety_en_i && strobe_req_i) |=> seq == seq_strobe;
  endproperty
  a_no_limit: assert property (p_no_limit) // [RULE_11]
    else $error("pulse cut with limit disabled");

  property p_flag_set_wins;
    @(posedge clock_i) disable iff (!rst_n_i)
      timeout_evt |=> timeout_flag;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) // [RULE_12]
    else $error("timeout event lost");

  property p_long_codes;
    @(posedge clock_i) disable iff (!rst_n_i)
      safety_code >= 3'h5 |-> safety_ms == 14'h0400;
  endproperty
  a_long_codes: assert property (p_long_codes) // [RULE_13]
    else $error("undefined duration code not clamped");

  property p_spare_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
      $past(reg_rd_i) && $past(reg_addr_i) == 8'h0d |-> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_spare_zero: assert property (p_spare_zero) // [RULE_14]
    else $error("spare bits read nonzero");
endmodule

// File: verilog/fld_params.svh
// Register map, field positions, reset values and timing figures of the flash LED config bank
`ifndef FLD_PARAMS_SVH
`define FLD_PARAMS_SVH

// ==========================================================
// Register offsets
`define FLD_ADDR_STROBE_LEVEL   8'h0c
`define FLD_ADDR_REDUCED_LEVEL  8'h0d
`define FLD_ADDR_STEADY_LIGHT   8'h0e
`define FLD_ADDR_PROTECTION     8'h0f
`define FLD_ADDR_STROBE_TIMER   8'h10
`define FLD_ADDR_STROBE_STATUS  8'h14

// ==========================================================
// Reset values (only defined field bits are stored)
`define FLD_RST_STROBE_LEVEL    7'h1f
`define FLD_RST_REDUCED_LEVEL   4'h0
`define FLD_RST_STEADY_LIGHT    6'h00
`define FLD_RST_PROTECTION      6'h20
`define FLD_RST_STROBE_TIMER    7'h13

// ==========================================================
// Field positions
`define FLD_STROBE_CODE_MSB     4
`define FLD_STROBE_CODE_LSB     0
`define FLD_STROBE_SLEW_MSB     6
`define FLD_STROBE_SLEW_LSB     5
`define FLD_STEADY_CODE_MSB     3
`define FLD_STEADY_CODE_LSB     0
`define FLD_STEADY_SLEW_MSB     5
`define FLD_STEADY_SLEW_LSB     4
`define FLD_BO_LOWER_MSB        1
`define FLD_BO_LOWER_LSB        0
`define FLD_BO_UPPER_MSB        3
`define FLD_BO_UPPER_LSB        2
`define FLD_PEAK_LIMIT_MSB      5
`define FLD_PEAK_LIMIT_LSB      4
`define FLD_SAFETY_MSB          2
`define FLD_SAFETY_LSB          0
`define FLD_INHIBIT_MSB         6
`define FLD_INHIBIT_LSB         3
`define FLD_STATUS_TIMEOUT_BIT  0

// ==========================================================
// Analog settings (mA, mV)
`define FLD_STROBE_STEP_MA      11'h064
`define FLD_STEADY_STEP_MA      11'h021
`define FLD_STROBE_MAX_MA       11'h640
`define FLD_BO_LOWER_BASE_MV    12'habe
`define FLD_BO_UPPER_BASE_MV    12'hb54
`define FLD_BO_STEP_MV          12'h096
`define FLD_PEAK_BASE_MA        12'h708
`define FLD_PEAK_STEP_MA        12'h258

// ==========================================================
// Timing
`define FLD_CLK_MHZ             50
`define FLD_TICK_US             1
`define FLD_TICK_CYCLES         (`FLD_TICK_US * `FLD_CLK_MHZ)
`define FLD_MS_IN_US            1000
`define FLD_STROBE_SLEW_BASE_US 12'h010
`define FLD_STEADY_SLEW_BASE_US 12'h040
`define FLD_SAFETY_BASE_MS      14'h0020
`define FLD_SAFETY_MAX_CODE     3'h5
`define FLD_INHIBIT_STEP_MS     14'h0200

`endif

// File: verilog/fld_pkg.sv
// Types shared by the flash LED config bank
package fld_pkg;
  typedef enum logic [1:0] {
    seq_idle    = 2'b00,
    seq_strobe  = 2'b01,
    seq_inhibit = 2'b10
  } fld_seq_t;

  typedef logic [10:0] fld_ma_t;
endpackage

// File: verilog/fld_tick.sv
// Event divider: one-cycle tick after every period_i counted input events
module fld_tick #(
  parameter int W = 12
) (
  input  wire logic         clock_i,   // System clock
  input  wire logic         rst_n_i,   // Async reset, active low
  input  wire logic         clr_i,     // Restart the count
  input  wire logic         inc_i,     // Event to count
  input  wire logic [W-1:0] period_i,  // Events per tick
  output logic              tick_o     // One-cycle tick
);
  logic [W-1:0] cnt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (clr_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (inc_i && (cnt >= period_i - W'(1))) begin
      cnt    <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt    <= inc_i ? cnt + W'(1) : cnt;
      tick_o <= 1'b0;
    end
  end
endmodule

// File: verif/fld_host_model.sv
// Host-side register master model for the flash LED config bank
module fld_host_model (
  input  wire logic       clock_i,      // System clock
  output logic      [7:0] reg_addr_o,   // Register offset
  output logic      [7:0] reg_wdata_o,  // Write data
  output logic            reg_wr_o,     // Write strobe
  output logic            reg_rd_o,     // Read strobe
  input  wire logic [7:0] reg_rdata_i   // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_o = 8'hff;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // ==========================================================
  // One-cycle strobes; released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
endmodule

// File: verif/test_flash_led_driver_config.sv
// Self-checking bench for the flash LED config bank
module test_flash_led_driver_config import fld_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i;
  logic        rst_n_i;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd;
  logic        sreq, red, treq, saf, inh;
  fld_ma_t     cur;
  logic        s_act, i_act;
  logic [11:0] lo_mv, hi_mv, pk_ma;
  int          mismatches;
  int          num_checks;
  logic [7:0]  d;
  int          n;

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Small time scale: 1 ms is 8 cycles, 1 us is 2 cycles
  fld_config #(.CYC_PER_US(2), .US_PER_MS(4)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .strobe_req_i(sreq),
    .reduced_i(red), .steady_req_i(treq), .safety_en_i(saf), .inhibit_en_i(inh),
    .led_current_ma_o(cur), .strobe_active_o(s_act), .inhibit_active_o(i_act),
    .brownout_lower_mv_o(lo_mv), .brownout_upper_mv_o(hi_mv),
    .boost_peak_limit_ma_o(pk_ma));
  fld_host_model u_host (
    .clock_i(clock_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata));

  // ==========================================================
  // Helpers
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input bit use_inh, input logic v, input int bound);
    n = 0;
    while (((use_inh ? i_act : s_act) !== v) && n < bound) begin
      @(negedge clock_i);
      n++;
    end
    if ((use_inh ? i_act : s_act) !== v) begin
      mismatches++;
      $display("ERROR %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clock_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] adr [5] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
    logic [7:0] rst [5] = '{8'h1f, 8'h00, 8'h00, 8'h20, 8'h13};
    for (int i = 0; i < 5; i++) begin
      u_host.rd(adr[i], d);
      chk(d, rst[i]);
    end
    u_host.wr(8'h0d, 8'hff);
    u_host.rd(8'h0d, d);
    chk(d, 8'h0f);
    u_host.wr(8'h0c, 8'hff);
    u_host.rd(8'h0c, d);
    chk(d, 8'h7f);
    u_host.wr(8'h20, 8'h5a);
    u_host.rd(8'h20, d);
    chk(d, 8'h00);
  endtask
  task automatic t_protect();
    for (int c = 0; c < 4; c++) begin
      u_host.wr(8'h0f, {2'b00, c[1:0], c[1:0], c[1:0]});
      u_host.rd(8'h0f, d);
      chk(d, {2'b00, c[1:0], c[1:0], c[1:0]});
      chk(lo_mv, 12'(2750 + 150 * c));
      chk(hi_mv, 12'(2900 + 150 * c));
      chk(pk_ma, 12'(1800 + 600 * c));
    end
  endtask
  task automatic t_levels();
    u_host.wr(8'h0c, 8'h0e);
    u_host.wr(8'h0d, 8'h03);
    sreq = 1'b1;
    idle(80);
    chk(cur, 12'h0c8);
    idle(220);
    chk(cur, 12'h258);
    red = 1'b1;
    idle(300);
    chk(cur, 12'h190);
    chk(s_act, 1'b1);
    sreq = 1'b0;
    red = 1'b0;
    idle(3);
    chk(s_act, 1'b0);
    chk(i_act, 1'b0);
    chk(cur, 12'h000);
  endtask
  task automatic t_steady();
    u_host.wr(8'h0e, 8'h0f);
    treq = 1'b1;
    idle(200);
    chk(cur, 12'h021);
    idle(2000);
    chk(cur, 12'h215);
    treq = 1'b0;
    idle(3);
  endtask
  // Slower slew codes: strobe 64 us per step, steady 512 us per step
  task automatic t_slew();
    u_host.wr(8'h0c, 8'h41);
    sreq = 1'b1;
    idle(100);
    chk(cur, 12'h000);
    idle(60);
    chk(cur, 12'h064);
    idle(160);
    chk(cur, 12'h085);
    sreq = 1'b0;
    u_host.wr(8'h0e, 8'h30);
    treq = 1'b1;
    idle(900);
    chk(cur, 12'h000);
    idle(200);
    chk(cur, 12'h021);
    treq = 1'b0;
    idle(3);
  endtask
  task automatic t_timers(input logic [7:0] cfg, input int lo, input int hi);
    u_host.wr(8'h10, cfg);
    u_host.wr(8'h0c, 8'h18);
    saf = 1'b1;
    sreq = 1'b1;
    wait_for(1'b0, 1'b1, 4);
    wait_for(1'b0, 1'b0, 9000);
    chk(12'(n >= lo && n <= hi), 12'h001);
    chk(i_act, inh);
    u_host.rd(8'h14, d);
    chk(d, 8'h01);
    u_host.rd(8'h14, d);
    chk(d, 8'h00);
    sreq = 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    {sreq, red, treq, saf, inh} = '0;
    mismatches = 0;
    num_checks = 0;
    idle(10);
    rst_n_i = 1'b1;
    t_regs();
    t_protect();
    t_levels();
    t_steady();
    t_slew();
    inh = 1'b1;
    t_timers(8'h00, 254, 258);
    wait_for(1'b1, 1'b0, 4200);
    chk(12'(n >= 4080 && n <= 4096), 12'h001);
    inh = 1'b0;
    t_timers(8'h07, 8190, 8194);
    idle(3);
    chk(i_act, 1'b0);
    wrap_up();
  end
endmodule
